/* fspc_flash_self_program_control.sv */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Reset vector chosen by boot select fuse
// - Core cannot write any fuse
// - Control resets zero; bit5 zero, bit6 read-only
// - Ready irq while enable clear and gated
// - Busy set on concurrent erase/write; blocks section
// - Read-enable command clears busy when idle
// - Buffer load clears busy flag
// - Read-enable during loading discards buffer
// - Lock command programs lock bits from low data
// - Load within three cycles returns lock/fuse
// - Page write from buffer to pointer page
// - Stall core on blocking-section erase/write
// - Page erase of pointer page
// - Plain enable loads word into buffer
// - Enable armed four cycles, held while busy
// - Only five command patterns take effect
// - Target address latched at operation start
// - Pointer low bits word, high bits page
// - Buffer words loadable in any order
// - Buffer cleared on write, read-enable, reset
// - Lock values from low data bits 5..2
// - Programmed bits read zero
// - EEPROM write blocks commands and read-back
module fspc_flash_self_program_control
  import fspc_pkg::*;
#(
  parameter int PAGE_WORDS_LOG2 = 6,
  parameter int PAGE_COUNT_LOG2 = 8,
  parameter int BLOCKING_FIRST_PAGE = 224,
  parameter logic [15:0] BOOT_START_ADDR = 16'h3800,
  parameter int PROG_CYCLES = FSPC_PROG_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core instruction side
  input wire logic store_program_instruction,
  input wire logic load_program_instruction,
  input wire logic [15:0] pointer,
  input wire logic [15:0] data_register_pair,
  input wire logic global_irq_enable,
  input wire logic eeprom_write_busy,
  output logic [7:0] load_data,
  output logic load_data_valid,
  output logic core_stall,
  output logic program_ready_irq,
  output logic concurrent_section_busy,
  output logic [15:0] reset_vector,
  // Fuses, from external programming only
  input wire logic boot_reset_select,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  // Flash array side
  output logic array_erase,
  output logic array_write,
  output logic [PAGE_COUNT_LOG2-1:0] array_page,
  output logic [15:0] array_data [0:(1<<PAGE_WORDS_LOG2)-1],
  output logic [7:0] lock_bits
);
  // ===========================================
  // Decode helpers
  function automatic logic [PAGE_COUNT_LOG2-1:0] page_of(input logic [15:0] p);
    page_of = p[PAGE_WORDS_LOG2+PAGE_COUNT_LOG2:PAGE_WORDS_LOG2+1];
  endfunction : page_of
  function automatic logic [PAGE_WORDS_LOG2-1:0] word_of(input logic [15:0] p);
    word_of = p[PAGE_WORDS_LOG2:1];
  endfunction : word_of

  localparam int WORDS = 1 << PAGE_WORDS_LOG2;
  fspc_state_type state_reg;
  logic [4:0] cmd_reg;
  logic irq_en_reg;
  logic busy_reg;
  logic [2:0] window_reg;
  logic [2:0] load_window_reg;
  logic [31:0] prog_count_reg;
  logic [PAGE_COUNT_LOG2-1:0] page_reg;
  logic is_write_reg;
  logic stall_reg;
  logic [15:0] buffer_reg [0:WORDS-1];
  logic [WORDS-1:0] filled_reg;
  logic [7:0] lock_reg;
  logic [7:0] load_data_reg;
  logic load_valid_reg;
  logic [7:0] rdata_reg;
  logic [15:0] vector_reg;

  logic ctrl_wr;
  logic cmd_valid;
  logic fire;
  logic start_prog;
  logic prog_done;
  logic blocking_target;
  assign ctrl_wr = reg_wr && reg_addr == FSPC_CTRL_ADDR;
  assign cmd_valid = reg_wdata[4:0] == FSPC_CMD_RRE || reg_wdata[4:0] == FSPC_CMD_LOCK
    || reg_wdata[4:0] == FSPC_CMD_PGWR || reg_wdata[4:0] == FSPC_CMD_PGER
    || reg_wdata[4:0] == FSPC_CMD_LOAD;
  assign fire = state_reg == FSPC_ARMED && store_program_instruction && !eeprom_write_busy;
  assign start_prog = fire && (cmd_reg == FSPC_CMD_PGWR || cmd_reg == FSPC_CMD_PGER);
  assign prog_done = state_reg == FSPC_BUSY && prog_count_reg == 32'h00000001;
  assign blocking_target = 32'(page_of(pointer)) >= BLOCKING_FIRST_PAGE;

  // ===========================================
  // Command sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= FSPC_IDLE;
      cmd_reg <= 5'h00;
      window_reg <= 3'h0;
      load_window_reg <= 3'h0;
      prog_count_reg <= 32'h0;
    end else begin
      case (state_reg)
        FSPC_IDLE: begin
          // Busy controller never accepts a new command; EEPROM write blocks too
          if (ctrl_wr && cmd_valid && !eeprom_write_busy) begin
            state_reg <= FSPC_ARMED;
            cmd_reg <= reg_wdata[4:0];
            window_reg <= FSPC_STORE_WINDOW;
            load_window_reg <= (reg_wdata[4:0] == FSPC_CMD_LOCK) ? FSPC_LOAD_WINDOW : 3'h0;
          end
        end
        FSPC_ARMED: begin
          if (load_window_reg != 3'h0) begin
            load_window_reg <= load_window_reg - 3'h1;
          end
          if (start_prog) begin
            state_reg <= FSPC_BUSY;
            prog_count_reg <= PROG_CYCLES;
            load_window_reg <= 3'h0;
          end else if (fire || window_reg == 3'h1
                       || (load_program_instruction && load_window_reg != 3'h0)) begin
            state_reg <= FSPC_IDLE;
            cmd_reg <= 5'h00;
            window_reg <= 3'h0;
            load_window_reg <= 3'h0;
          end else begin
            window_reg <= window_reg - 3'h1;
          end
        end
        FSPC_BUSY: begin
          prog_count_reg <= prog_count_reg - 32'h1;
          if (prog_done) begin
            state_reg <= FSPC_IDLE;
            cmd_reg <= 5'h00;
          end
        end
        default: begin
          state_reg <= FSPC_IDLE;
          cmd_reg <= 5'h00;
        end
      endcase
    end
  end

  // ===========================================
  // Interrupt enable, busy flag, latched target
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_reg <= reg_wdata[FSPC_BIT_IRQ_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (start_prog && !blocking_target) begin
      busy_reg <= 1'b1;
    end else if (fire && (cmd_reg == FSPC_CMD_LOAD || cmd_reg == FSPC_CMD_RRE)) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      page_reg <= '0;
      is_write_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else if (start_prog) begin
      page_reg <= page_of(pointer);
      is_write_reg <= cmd_reg == FSPC_CMD_PGWR;
      stall_reg <= blocking_target;
    end else if (prog_done) begin
      stall_reg <= 1'b0;
    end
  end

  // ===========================================
  // Temporary page buffer, random order fill
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filled_reg <= '0;
    end else if ((prog_done && is_write_reg) || (fire && cmd_reg == FSPC_CMD_RRE)) begin
      filled_reg <= '0;
    end else if (fire && cmd_reg == FSPC_CMD_LOAD) begin
      filled_reg[word_of(pointer)] <= 1'b1;
    end
  end

  // Erased words read as all ones, like erased flash
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < WORDS; i++) begin
      if (!rst_n || (prog_done && is_write_reg) || (fire && cmd_reg == FSPC_CMD_RRE)) begin
        buffer_reg[i] <= 16'hffff;
      end else if (fire && cmd_reg == FSPC_CMD_LOAD && word_of(pointer) == i[PAGE_WORDS_LOG2-1:0]
                   && !filled_reg[i]) begin
        buffer_reg[i] <= data_register_pair;
      end
    end
  end

  // ===========================================
  // Lock bits; software can only program, never clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_reg <= FSPC_LOCK_RESET;
    end else if (fire && cmd_reg == FSPC_CMD_LOCK) begin
      lock_reg[5:2] <= lock_reg[5:2] & data_register_pair[5:2];
    end
  end

  // ===========================================
  // Load-program read-back
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      load_data_reg <= 8'h00;
      load_valid_reg <= 1'b0;
    end else begin
      load_valid_reg <= 1'b0;
      if (state_reg == FSPC_ARMED && load_program_instruction && load_window_reg != 3'h0
          && !eeprom_write_busy) begin
        load_valid_reg <= 1'b1;
        // Raw values: zero means programmed
        // Pointer 3 is the high fuse byte, so test both bits before bit 0
        if (pointer[1:0] == 2'h3) begin
          load_data_reg <= fuse_high;
        end else if (pointer[0]) begin
          load_data_reg <= lock_reg;
        end else begin
          load_data_reg <= fuse_low;
        end
      end
    end
  end

  // ===========================================
  // Reset vector, caught after reset release
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vector_reg <= FSPC_APP_RESET_ADDR;
    end else if (state_reg == FSPC_IDLE && vector_reg == FSPC_APP_RESET_ADDR && !boot_reset_select) begin
      vector_reg <= BOOT_START_ADDR;
    end
  end

  // ===========================================
  // Register read; fuses have no write path at all
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == FSPC_CTRL_ADDR) begin
        rdata_reg <= {irq_en_reg, busy_reg, 1'b0, cmd_reg};
      end else if (reg_addr == FSPC_FUSE_ADDR) begin
        rdata_reg <= fuse_low;
      end else if (reg_addr == FSPC_STAT_ADDR) begin
        rdata_reg <= {5'h00, stall_reg, load_valid_reg, eeprom_write_busy};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign load_data = load_data_reg;
  assign load_data_valid = load_valid_reg;
  assign core_stall = stall_reg;
  assign program_ready_irq = irq_en_reg && global_irq_enable && !cmd_reg[FSPC_BIT_SPE];
  assign concurrent_section_busy = busy_reg;
  assign reset_vector = vector_reg;
  assign array_erase = state_reg == FSPC_BUSY && !is_write_reg;
  assign array_write = state_reg == FSPC_BUSY && is_write_reg;
  assign array_page = page_reg;
  assign array_data = buffer_reg;
  assign lock_bits = lock_reg;
endmodule : fspc_flash_self_program_control
`default_nettype wire

/* fspc_pkg.sv */
package fspc_pkg;
  // ===========================================
  // Register layout
  localparam logic [1:0] FSPC_CTRL_ADDR = 2'h0;
  localparam logic [1:0] FSPC_FUSE_ADDR = 2'h1;
  localparam logic [1:0] FSPC_STAT_ADDR = 2'h2;
  localparam logic [7:0] FSPC_CTRL_RESET = 8'h00;
  localparam int FSPC_BIT_IRQ_EN = 7;
  localparam int FSPC_BIT_BUSY = 6;
  localparam int FSPC_BIT_RES = 5;
  localparam int FSPC_BIT_RRE = 4;
  localparam int FSPC_BIT_LOCK = 3;
  localparam int FSPC_BIT_PGWR = 2;
  localparam int FSPC_BIT_PGER = 1;
  localparam int FSPC_BIT_SPE = 0;
  // ===========================================
  // Command patterns in the low five bits
  localparam logic [4:0] FSPC_CMD_RRE = 5'h11;
  localparam logic [4:0] FSPC_CMD_LOCK = 5'h09;
  localparam logic [4:0] FSPC_CMD_PGWR = 5'h05;
  localparam logic [4:0] FSPC_CMD_PGER = 5'h03;
  localparam logic [4:0] FSPC_CMD_LOAD = 5'h01;
  // ===========================================
  // Timing and reset values
  localparam logic [2:0] FSPC_STORE_WINDOW = 3'h4;
  localparam logic [2:0] FSPC_LOAD_WINDOW = 3'h3;
  localparam logic [15:0] FSPC_APP_RESET_ADDR = 16'h0000;
  localparam logic [7:0] FSPC_LOCK_RESET = 8'hff;
  localparam int FSPC_PROG_TIME_US = 4000;
  localparam int FSPC_CLK_MHZ = 20;
  localparam int FSPC_PROG_CYCLES = FSPC_PROG_TIME_US * FSPC_CLK_MHZ;
  typedef enum logic [2:0] {
    FSPC_IDLE = 3'b001,
    FSPC_ARMED = 3'b010,
    FSPC_BUSY = 3'b100
  } fspc_state_type;
endpackage : fspc_pkg

/* fspc_flash_self_program_control_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_flash_self_program_control_asserts #(
  parameter int PAGE_COUNT_LOG2 = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core side
  input wire logic store_program_instruction,
  input wire logic load_program_instruction,
  input wire logic global_irq_enable,
  input wire logic eeprom_write_busy,
  input wire logic load_data_valid,
  input wire logic core_stall,
  input wire logic program_ready_irq,
  input wire logic concurrent_section_busy,
  // Array side
  input wire logic array_erase,
  input wire logic array_write,
  input wire logic [PAGE_COUNT_LOG2-1:0] array_page
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire prog_active = array_erase | array_write;
  // ===========================================
  // Properties
  property p_irq; program_ready_irq |-> global_irq_enable; endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
  property p_stall; core_stall |-> prog_active; endproperty
  a_stall: assert property (p_stall) else $error("stall outside operation");
  property p_load; load_data_valid |-> $past(load_program_instruction); endproperty
  a_load: assert property (p_load) else $error("load data without load");
  property p_start; $rose(prog_active) |-> $past(store_program_instruction); endproperty
  a_start: assert property (p_start) else $error("operation without store");
  property p_page; prog_active && $past(prog_active) |-> $stable(array_page); endproperty
  a_page: assert property (p_page) else $error("page moved mid operation");
  // Short count stands in for the long array time
  property p_len; $rose(prog_active) |-> prog_active [*4] ##[1:12] !prog_active; endproperty
  a_len: assert property (p_len) else $error("operation length wrong");
  property p_eeprom; $past(eeprom_write_busy) |-> !$rose(prog_active) && !load_data_valid; endproperty
  a_eeprom: assert property (p_eeprom) else $error("action during eeprom write");
  property p_busy; $rose(concurrent_section_busy) |-> prog_active; endproperty
  a_busy: assert property (p_busy) else $error("busy set without operation");
endmodule : fspc_flash_self_program_control_asserts
bind fspc_flash_self_program_control fspc_flash_self_program_control_asserts #(
  .PAGE_COUNT_LOG2(PAGE_COUNT_LOG2)
) u_chk (.ref_clk, .rst_n, .store_program_instruction, .load_program_instruction, .global_irq_enable,
  .eeprom_write_busy, .load_data_valid, .core_stall, .program_ready_irq, .concurrent_section_busy,
  .array_erase, .array_write, .array_page);
`default_nettype wire

/* fspc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_core_model (
  // Clock
  input wire logic ref_clk,
  // Instruction side
  output logic store_program_instruction,
  output logic load_program_instruction,
  output logic [15:0] pointer,
  output logic [15:0] data_register_pair
);
  initial begin
    store_program_instruction = 1'h0;
    load_program_instruction = 1'h0;
    pointer = 16'h0000;
    data_register_pair = 16'h0000;
  end
  // One instruction, d idle cycles late; pointer stays put afterwards
  task automatic ins(input logic ld, input int d, input logic [15:0] p, x);
    repeat (d + 1) @(posedge ref_clk);
    pointer <= p;
    data_register_pair <= x;
    store_program_instruction <= !ld;
    load_program_instruction <= ld;
    @(posedge ref_clk);
    store_program_instruction <= 1'h0;
    load_program_instruction <= 1'h0;
    // Return where the answer of the taken instruction has settled
    @(negedge ref_clk);
  endtask : ins
endmodule : fspc_core_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fspc_pkg::*;
  localparam logic [15:0] BOOT = 16'h3800;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, gie = 0, ee = 0;
  logic [1:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, load_data, lock_bits, array_page;
  logic [15:0] pointer, data_register_pair, reset_vector;
  logic store_program_instruction, load_program_instruction, load_data_valid, core_stall;
  logic program_ready_irq, concurrent_section_busy, array_erase, array_write;
  logic [15:0] array_data [0:63];
  logic [7:0] bad [5] = '{8'h07, 8'h0b, 8'h13, 8'h19, 8'h1f};
  int bad_count = 0, num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  fspc_core_model core (.ref_clk, .store_program_instruction, .load_program_instruction, .pointer,
    .data_register_pair);
  fspc_flash_self_program_control #(.PROG_CYCLES(8), .BOOT_START_ADDR(BOOT)) dut (.ref_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .store_program_instruction,
    .load_program_instruction, .pointer, .data_register_pair, .global_irq_enable(gie),
    .eeprom_write_busy(ee), .load_data, .load_data_valid, .core_stall, .program_ready_irq,
    .concurrent_section_busy, .reset_vector, .boot_reset_select(1'h0), .fuse_low(8'h5a),
    .fuse_high(8'ha5), .array_erase, .array_write, .array_page, .array_data, .lock_bits);
  // ===========================================
  // Tasks
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask : rd
  // Bounded wait for the array to go quiet
  task automatic idle;
    repeat (40) begin
      @(negedge ref_clk);
      if (!(array_erase || array_write)) break;
    end
    chk(array_erase | array_write, 0);
  endtask : idle
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  // ===========================================
  // Tests
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(negedge ref_clk);
    chk(reset_vector, BOOT);
    chk(array_data[9], 16'hffff);
    rd(FSPC_CTRL_ADDR, 8'h00);
    wr(FSPC_CTRL_ADDR, 8'h20);
    rd(FSPC_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(FSPC_CTRL_ADDR, bad[i]);
      rd(FSPC_CTRL_ADDR, 8'h00);
    end
    wr(FSPC_CTRL_ADDR, 8'h80);
    gie <= 1'h1;
    rd(FSPC_CTRL_ADDR, 8'h80);
    chk(program_ready_irq, 1);
    wr(FSPC_CTRL_ADDR, 8'h00);
    gie <= 1'h0;
    wr(FSPC_FUSE_ADDR, 8'h00);
    rd(FSPC_FUSE_ADDR, 8'h5a);
    rd(2'h3, 8'h00);
    $display("test registers done");
    wr(FSPC_CTRL_ADDR, 8'h01);
    core.ins(0, 2, 16'h018b, 16'h1234);
    chk(array_data[5], 16'h1234);
    wr(FSPC_CTRL_ADDR, 8'h01);
    core.ins(0, 3, 16'h0184, 16'h5678);
    chk(array_data[2], 16'hffff);
    rd(FSPC_CTRL_ADDR, 8'h00);
    wr(FSPC_CTRL_ADDR, 8'h01);
    core.ins(0, 0, 16'h0184, 16'h5678);
    chk(array_data[2], 16'h5678);
    wr(FSPC_CTRL_ADDR, 8'h11);
    core.ins(0, 0, 16'h0000, 16'h0000);
    chk(array_data[5], 16'hffff);
    $display("test buffer done");
    wr(FSPC_CTRL_ADDR, 8'h03);
    core.ins(0, 0, 16'h7300, 16'h0000);
    chk(core_stall, 1);
    idle();
    wr(FSPC_CTRL_ADDR, 8'h03);
    core.ins(0, 0, 16'h0180, 16'h0000);
    core.ins(0, 0, 16'h7fff, 16'h0000);
    chk(array_page, 8'h03);
    chk(concurrent_section_busy, 1);
    wr(FSPC_CTRL_ADDR, 8'h11);
    rd(FSPC_CTRL_ADDR, 8'h43);
    idle();
    rd(FSPC_CTRL_ADDR, 8'h40);
    wr(FSPC_CTRL_ADDR, 8'h01);
    core.ins(0, 0, 16'h7302, 16'hbeef);
    chk(concurrent_section_busy, 0);
    wr(FSPC_CTRL_ADDR, 8'h05);
    core.ins(0, 0, 16'h7300, 16'h0000);
    chk(core_stall, 1);
    idle();
    chk(array_data[1], 16'hffff);
    wr(FSPC_CTRL_ADDR, 8'h05);
    core.ins(0, 0, 16'h0180, 16'h0000);
    idle();
    chk(concurrent_section_busy, 1);
    wr(FSPC_CTRL_ADDR, 8'h11);
    core.ins(0, 0, 16'h0000, 16'h0000);
    chk(concurrent_section_busy, 0);
    $display("test program done");
    wr(FSPC_CTRL_ADDR, 8'h09);
    core.ins(1, 0, 16'h0001, 16'h0000);
    chk(load_data_valid, 1);
    chk(load_data, 8'hff);
    // Third cycle after the write is the last one taken
    wr(FSPC_CTRL_ADDR, 8'h09);
    core.ins(1, 1, 16'h0000, 16'h0000);
    chk(load_data, 8'h5a);
    wr(FSPC_CTRL_ADDR, 8'h09);
    core.ins(1, 0, 16'h0003, 16'h0000);
    chk(load_data, 8'ha5);
    wr(FSPC_CTRL_ADDR, 8'h09);
    core.ins(0, 0, 16'h1234, 16'hffc3);
    rd(FSPC_CTRL_ADDR, 8'h00);
    chk(lock_bits, 8'hc3);
    $display("test lock done");
    ee <= 1'h1;
    wr(FSPC_CTRL_ADDR, 8'h03);
    core.ins(0, 0, 16'h0180, 16'h0000);
    chk(array_erase, 0);
    rd(FSPC_CTRL_ADDR, 8'h00);
    ee <= 1'h0;
    $display("test eeprom done");
    test_done();
  end
endmodule : tb
`default_nettype wire
